// *** hw/fts_fix_store.sv ***
// float-to-integer store sequencer with its avalon-mm register slave
// assumes: accumulator, memory bus and processor handshake all run on clk
//
// Function
// - truncate fraction, never round
// - negative exponent stores zero, positive sign
// - exponent code msb one means non-negative
// - fifteen minus exponent, non-negative means range
// - counter gets 143 minus code, carry if non-negative
// - top magnitude bit lands on integer bit 14
// - shift right per clock until count zero
// - clear constant register before in-range store
// - truncate via zero-filled mq before complementing
// - clear sign flag before storing complemented value
// - bus carries bits 32-47 of constant plus work
// - one write, wait completion, then return control
// - positive overflow stores max, sets interrupt
// - negative overflow stores min; exact limit no flag
// - exponent sixteen test by increment carry out
// - out-of-range loads one into constant bit 47
// - restore fraction and sign, exponent unchanged
// - sign flag high inverts bus data
`timescale 1ns/1ps
`include "fts_params.svh"

module fts_fix_store #(
    parameter int AV_ADDR_W = 4
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // accumulator datapath
    input  wire logic                         start,
    input  wire fts_pkg::fts_acc_t            acc_in,
    input  wire logic [`FTS_MEM_ADDR_W-1:0]   store_addr,
    output fts_pkg::fts_acc_t                 acc_out,
    output logic                              busy,
    // memory bus
    output fts_pkg::fts_mem_wr_t              mem_wr,
    input  wire logic                         mem_done,
    // processor handshake
    output logic                              return_control,
    output logic                              irq,
    // avalon-mm slave
    input  wire logic [AV_ADDR_W-1:0]         avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest
);

    // refused at elaboration: the register decode reads four address bits
    if (AV_ADDR_W < 4) begin : g_addr_w_check
        $error("fts_fix_store: AV_ADDR_W must be at least 4");
    end

    fts_pkg::fts_state_t            state_q;
    logic [`FTS_FRAC_W-1:0]         save_q;          // fraction kept for restore
    logic [`FTS_FRAC_W-1:0]         work_q;
    logic [`FTS_FRAC_W-1:0]         constant_reg_q;
    logic [`FTS_FRAC_W-1:0]         mult_quot_reg_q;
    logic [`FTS_EXP_W-1:0]          exp_q;
    logic [`FTS_EXP_W-1:0]          shift_counter_q;
    logic                           accum_sign_flag_q;
    logic                           saved_sign_flag_q;
    logic                           exp_carry_flag_q;
    logic                           zero_flag_q;
    logic                           ovf_event;
    logic                           done_event;
    logic [`FTS_FRAC_W-1:0]         alu_sum;
    logic [`FTS_INT_W-1:0]          bus_word;
    logic [`FTS_EXP_W:0]            diff15;
    logic [`FTS_EXP_W:0]            inc_exp;
    logic [`FTS_IRQ_W-1:0]          status_q;
    logic [`FTS_IRQ_W-1:0]          mask_q;
    logic [`FTS_INT_W-1:0]          result_q;
    logic                           acc_valid_q;
    logic                           bus_req;
    logic                           bus_hit_wr;
    logic [3:0]                     reg_off;
    fts_pkg::fts_mem_wr_t           mem_wr_q;
    fts_pkg::fts_acc_t              acc_out_q;
    logic                           ret_q;
    logic                           irq_q;
    logic [31:0]                    rdata_q;
    logic                           wait_q;
    logic                           busy_q;

    fts_store_path u_store_path (
        .const_reg       (constant_reg_q),
        .work_reg        (work_q),
        .accum_sign_flag (accum_sign_flag_q),
        .alu_sum         (alu_sum),
        .bus_word        (bus_word)
    );

    // 9-bit results keep the carry out of the exponent loop
    assign diff15  = `FTS_EXP_BIAS15 - {1'b0, shift_counter_q};
    assign inc_exp = {1'b0, exp_q} + 9'h0_001;

    assign ovf_event  = (state_q == fts_pkg::S_POS_MAX)
                        || (state_q == fts_pkg::S_NEG_MAX)
                        || (state_q == fts_pkg::S_LIM_OFL);
    assign done_event = (state_q == fts_pkg::S_STORE_WAIT) && mem_done;

    // sequencer state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= fts_pkg::S_IDLE;
            busy_q  <= 1'b0;
        end else begin
            case (state_q)
                fts_pkg::S_IDLE: begin
                    if (start) begin
                        state_q <= fts_pkg::S_LOAD;
                        busy_q  <= 1'b1;
                    end
                end
                fts_pkg::S_LOAD: begin
                    // exponent code msb decides the sign of the true exponent
                    state_q <= exp_q[`FTS_EXP_MSB] ? fts_pkg::S_DIFF
                                                   : fts_pkg::S_ZERO;
                end
                fts_pkg::S_ZERO:       state_q <= fts_pkg::S_STORE_REQ;
                fts_pkg::S_DIFF:       state_q <= fts_pkg::S_SIGN;
                fts_pkg::S_SIGN: begin
                    state_q <= exp_carry_flag_q ? fts_pkg::S_ALIGN
                                                : fts_pkg::S_OOR_XFER;
                end
                fts_pkg::S_ALIGN: begin
                    if (shift_counter_q == '0) begin
                        state_q <= accum_sign_flag_q ? fts_pkg::S_TRUNC
                                                     : fts_pkg::S_STORE_REQ;
                    end
                end
                fts_pkg::S_TRUNC:      state_q <= fts_pkg::S_RELOAD;
                fts_pkg::S_RELOAD:     state_q <= fts_pkg::S_NEG;
                fts_pkg::S_NEG:        state_q <= fts_pkg::S_STORE_REQ;
                fts_pkg::S_OOR_XFER:   state_q <= fts_pkg::S_EXP16;
                fts_pkg::S_EXP16: begin
                    state_q <= accum_sign_flag_q ? fts_pkg::S_NEG_SHIFT
                                                 : fts_pkg::S_POS_MAX;
                end
                fts_pkg::S_POS_MAX:    state_q <= fts_pkg::S_STORE_REQ;
                fts_pkg::S_NEG_SHIFT: begin
                    state_q <= exp_carry_flag_q ? fts_pkg::S_LIM_ADD
                                                : fts_pkg::S_NEG_MAX;
                end
                fts_pkg::S_NEG_MAX:    state_q <= fts_pkg::S_STORE_REQ;
                fts_pkg::S_LIM_ADD:    state_q <= fts_pkg::S_LIM_MOVE;
                fts_pkg::S_LIM_MOVE:   state_q <= fts_pkg::S_LIM_TEST;
                fts_pkg::S_LIM_TEST:   state_q <= fts_pkg::S_LIM_ONES;
                fts_pkg::S_LIM_ONES: begin
                    state_q <= zero_flag_q ? fts_pkg::S_STORE_REQ
                                           : fts_pkg::S_LIM_OFL;
                end
                fts_pkg::S_LIM_OFL:    state_q <= fts_pkg::S_STORE_REQ;
                fts_pkg::S_STORE_REQ:  state_q <= fts_pkg::S_STORE_WAIT;
                fts_pkg::S_STORE_WAIT: begin
                    if (mem_done) begin
                        state_q <= fts_pkg::S_RESTORE;
                    end
                end
                fts_pkg::S_RESTORE: begin
                    state_q <= fts_pkg::S_IDLE;
                    busy_q  <= 1'b0;
                end
                default: begin
                    state_q <= fts_pkg::S_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // working fraction, saved fraction and multiplier-quotient register
    always_ff @(posedge clk) begin
        if (reset) begin
            work_q          <= '0;
            save_q          <= '0;
            mult_quot_reg_q <= '0;
        end else begin
            case (state_q)
                fts_pkg::S_IDLE: begin
                    if (start) begin
                        work_q          <= acc_in.frac;
                        save_q          <= acc_in.frac;
                        mult_quot_reg_q <= '0;
                    end
                end
                fts_pkg::S_ZERO:      work_q <= '0;
                fts_pkg::S_ALIGN: begin
                    // no shift at all when the exponent is exactly fifteen
                    if (shift_counter_q != '0) begin
                        work_q <= work_q >> 1;
                    end
                end
                fts_pkg::S_TRUNC: begin
                    mult_quot_reg_q <= {work_q[`FTS_INT_LSB +: `FTS_INT_W],
                                        {`FTS_INT_LSB{1'b0}}};
                end
                fts_pkg::S_RELOAD:    work_q <= mult_quot_reg_q;
                fts_pkg::S_NEG:       work_q <= '0 - work_q;
                fts_pkg::S_POS_MAX:   work_q <= `FTS_ALL_ONES;
                fts_pkg::S_NEG_SHIFT: work_q <= save_q << 1;
                fts_pkg::S_NEG_MAX:   work_q <= `FTS_ALL_ONES;
                fts_pkg::S_LIM_ADD: begin
                    mult_quot_reg_q <= {alu_sum[`FTS_INT_LSB +: `FTS_INT_W],
                                        {`FTS_INT_LSB{1'b0}}};
                end
                fts_pkg::S_LIM_MOVE:  work_q <= mult_quot_reg_q;
                fts_pkg::S_LIM_ONES:  work_q <= `FTS_ALL_ONES;
                fts_pkg::S_RESTORE:   work_q <= save_q;
                default: begin
                end
            endcase
        end
    end

    // constant register
    always_ff @(posedge clk) begin
        if (reset) begin
            constant_reg_q <= '0;
        end else if (state_q == fts_pkg::S_IDLE && start) begin
            constant_reg_q <= `FTS_CR_START;
        end else if (state_q == fts_pkg::S_ALIGN && shift_counter_q == '0) begin
            constant_reg_q <= '0;
        end else if (state_q == fts_pkg::S_EXP16) begin
            constant_reg_q <= `FTS_CR_TOP;
        end
    end

    // exponent, shift counter, carry and zero flags
    always_ff @(posedge clk) begin
        if (reset) begin
            exp_q            <= '0;
            shift_counter_q  <= '0;
            exp_carry_flag_q <= 1'b0;
            zero_flag_q      <= 1'b0;
        end else begin
            case (state_q)
                fts_pkg::S_IDLE: begin
                    if (start) begin
                        exp_q <= acc_in.exp;
                    end
                end
                fts_pkg::S_LOAD:      shift_counter_q <= exp_q;
                fts_pkg::S_DIFF: begin
                    shift_counter_q  <= diff15[`FTS_EXP_W-1:0];
                    exp_carry_flag_q <= ~diff15[`FTS_EXP_W];
                end
                fts_pkg::S_ALIGN: begin
                    if (shift_counter_q != '0) begin
                        shift_counter_q <= shift_counter_q - 8'h01;
                    end
                end
                fts_pkg::S_OOR_XFER:  exp_q <= shift_counter_q;
                fts_pkg::S_EXP16: begin
                    // negative difference of -1 carries out only for exponent 16
                    exp_carry_flag_q <= inc_exp[`FTS_EXP_W];
                end
                fts_pkg::S_POS_MAX,
                fts_pkg::S_NEG_SHIFT: begin
                    exp_q <= diff15[`FTS_EXP_W-1:0];
                end
                fts_pkg::S_LIM_TEST:  zero_flag_q <= (work_q == '0);
                default: begin
                end
            endcase
        end
    end

    // accumulator and saved sign flags
    always_ff @(posedge clk) begin
        if (reset) begin
            accum_sign_flag_q <= 1'b0;
            saved_sign_flag_q <= 1'b0;
        end else begin
            case (state_q)
                fts_pkg::S_IDLE: begin
                    if (start) begin
                        accum_sign_flag_q <= acc_in.sign;
                        saved_sign_flag_q <= 1'b0;
                    end
                end
                fts_pkg::S_LOAD,
                fts_pkg::S_SIGN: begin
                    accum_sign_flag_q <= saved_sign_flag_q;
                    saved_sign_flag_q <= accum_sign_flag_q;
                end
                fts_pkg::S_ZERO,
                fts_pkg::S_DIFF:      accum_sign_flag_q <= 1'b0;
                fts_pkg::S_NEG: begin
                    accum_sign_flag_q <= saved_sign_flag_q;
                    saved_sign_flag_q <= accum_sign_flag_q;
                end
                fts_pkg::S_RESTORE: begin
                    // the original sign sits in whichever flag is set
                    accum_sign_flag_q <= accum_sign_flag_q | saved_sign_flag_q;
                    saved_sign_flag_q <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // memory write request, result capture and return of control
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_wr_q <= '0;
            result_q <= '0;
            ret_q    <= 1'b0;
        end else begin
            ret_q <= done_event;
            if (state_q == fts_pkg::S_IDLE && start) begin
                mem_wr_q.addr <= store_addr;
            end
            if (state_q == fts_pkg::S_STORE_REQ) begin
                mem_wr_q.req  <= 1'b1;
                mem_wr_q.data <= bus_word;
                result_q      <= bus_word;
            end else if (done_event) begin
                mem_wr_q.req  <= 1'b0;
            end
        end
    end

    // accumulator presented back to the datapath once restored
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_out_q   <= '0;
            acc_valid_q <= 1'b0;
        end else if (state_q == fts_pkg::S_IDLE && start) begin
            acc_valid_q <= 1'b0;
        end else if (state_q == fts_pkg::S_RESTORE) begin
            acc_out_q.frac <= save_q;
            acc_out_q.exp  <= exp_q;
            acc_out_q.sign <= accum_sign_flag_q | saved_sign_flag_q;
            acc_valid_q    <= 1'b1;
        end
    end

    // sticky status: set wins over a same-cycle write-one-to-clear
    assign reg_off    = avs_address[3:0];
    assign bus_req    = (avs_read || avs_write) && wait_q;
    // a write lands only at the edge where waitrequest is seen low
    assign bus_hit_wr = avs_write && !wait_q && avs_byteenable[0];

    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            if (bus_hit_wr && reg_off == `FTS_REG_STATUS) begin
                status_q <= status_q & ~avs_writedata[`FTS_IRQ_W-1:0];
            end
            if (ovf_event) begin
                status_q[`FTS_IRQ_OVF] <= 1'b1;
            end
            if (done_event) begin
                status_q[`FTS_IRQ_DONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= `FTS_MASK_RESET;
        end else if (bus_hit_wr && reg_off == `FTS_REG_MASK) begin
            mask_q <= avs_writedata[`FTS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // one wait cycle per access keeps read data a registered value
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end else if (bus_req) begin
            wait_q  <= 1'b0;
            rdata_q <= '0;
            if (avs_read) begin
                case (reg_off)
                    `FTS_REG_STATUS: rdata_q <= {30'h0, status_q};
                    `FTS_REG_MASK:   rdata_q <= {30'h0, mask_q};
                    `FTS_REG_RESULT: rdata_q <= {16'h0, result_q};
                    `FTS_REG_STATE:  rdata_q <= {27'h0, acc_valid_q, zero_flag_q,
                                                 accum_sign_flag_q, saved_sign_flag_q,
                                                 state_q != fts_pkg::S_IDLE};
                    default:         rdata_q <= '0;
                endcase
            end
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign busy            = busy_q;
    assign acc_out         = acc_out_q;
    assign mem_wr          = mem_wr_q;
    assign return_control  = ret_q;
    assign irq             = irq_q;
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

endmodule

// *** hw/fts_params.svh ***
// offsets, field positions, reset values and fixed constants of the float-to-integer store
// assumes: included by bare name from the package and the sequencer
`ifndef FTS_PARAMS_SVH
`define FTS_PARAMS_SVH

// accumulator layout
`define FTS_FRAC_W        48
`define FTS_EXP_W         8
`define FTS_INT_W         16
`define FTS_INT_LSB       32
`define FTS_SIGN_POS      47
`define FTS_MEM_ADDR_W    16

// exponent arithmetic: 143 is the excess-128 code for 15
`define FTS_EXP_BIAS15    9'h0_08F
`define FTS_EXP_MSB       7

// constant register contents and the all-ones work register value
`define FTS_CR_START      48'h0000_0000_0001
`define FTS_CR_TOP        48'h8000_0000_0000
`define FTS_ALL_ONES      48'hFFFF_FFFF_FFFF

// register offsets (byte addresses)
`define FTS_REG_STATUS    4'h0
`define FTS_REG_MASK      4'h4
`define FTS_REG_RESULT    4'h8
`define FTS_REG_STATE     4'hC

// status / mask bit positions
`define FTS_IRQ_OVF       0
`define FTS_IRQ_DONE      1
`define FTS_IRQ_W         2
`define FTS_MASK_RESET    2'h0

`endif

// *** hw/fts_pkg.sv ***
// types shared by the float-to-integer store sequencer, its bench, its assertions and its memory model
// assumes: fts_params.svh is on the include path
`include "fts_params.svh"

package fts_pkg;

    typedef struct packed {
        logic                        sign;
        logic [`FTS_EXP_W-1:0]       exp;
        logic [`FTS_FRAC_W-1:0]      frac;
    } fts_acc_t;

    typedef struct packed {
        logic                        req;
        logic [`FTS_MEM_ADDR_W-1:0]  addr;
        logic [`FTS_INT_W-1:0]       data;
    } fts_mem_wr_t;

    typedef enum logic [4:0] {
        S_IDLE, S_LOAD, S_ZERO, S_DIFF, S_SIGN, S_ALIGN, S_TRUNC, S_RELOAD,
        S_NEG, S_OOR_XFER, S_EXP16, S_POS_MAX, S_NEG_SHIFT, S_NEG_MAX,
        S_LIM_ADD, S_LIM_MOVE, S_LIM_TEST, S_LIM_ONES, S_LIM_OFL,
        S_STORE_REQ, S_STORE_WAIT, S_RESTORE
    } fts_state_t;

endpackage

// *** hw/fts_store_path.sv ***
// data-loop adder and output multiplexer toward the memory data bus
// assumes: purely combinational, fed from registers of the sequencer
`timescale 1ns/1ps
`include "fts_params.svh"

module fts_store_path (
    // operands
    input  wire logic [`FTS_FRAC_W-1:0] const_reg,
    input  wire logic [`FTS_FRAC_W-1:0] work_reg,
    input  wire logic                   accum_sign_flag,
    // results
    output logic      [`FTS_FRAC_W-1:0] alu_sum,
    output logic      [`FTS_INT_W-1:0]  bus_word
);

    // wraps at 48 bits, as the limit test relies on
    assign alu_sum  = const_reg + work_reg;
    // only the top sixteen bits reach the bus, so the fraction is simply dropped
    assign bus_word = alu_sum[`FTS_INT_LSB +: `FTS_INT_W]
                      ^ {`FTS_INT_W{accum_sign_flag}};

endmodule

// *** verif/float_to_integer_store_tb.sv ***
// self-checking bench for the float-to-integer store sequencer
// assumes: fts_pkg compiled first, memory partner in fts_mem_model
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module float_to_integer_store_tb;
    logic clk = 1'b0;
    logic reset, start, mem_done, avs_read, avs_write, busy, irq, return_control, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable, dly;
    logic [15:0] store_addr, last_data;
    logic [31:0] avs_writedata, avs_readdata, r;
    fts_pkg::fts_acc_t acc_in, acc_out;
    fts_pkg::fts_mem_wr_t mem_wr;
    int fails = 0, tests_run = 0, cyc = 0, seed, mask_on;
    fts_pkg::fts_acc_t corner [10] = '{{1'b0, 8'h7F, 48'h4000_0000_0000},
        {1'b1, 8'h7F, 48'h7FFF_FFFF_FFFF}, {1'b0, 8'h80, 48'h4000_0000_0000},
        {1'b1, 8'h82, 48'h7800_0000_0000}, {1'b0, 8'h8F, 48'h7FFF_FFFF_FFFF},
        {1'b1, 8'h8F, 48'h4000_0000_0001}, {1'b0, 8'h90, 48'h4000_0000_0000},
        {1'b1, 8'h90, 48'h4000_0000_0001}, {1'b1, 8'h90, 48'h4000_8000_0000},
        {1'b1, 8'hFF, 48'h7FFF_FFFF_FFFF}};
    always #12.5 clk = ~clk;
    fts_fix_store dut_u (.clk(clk), .reset(reset), .start(start), .acc_in(acc_in),
        .store_addr(store_addr), .acc_out(acc_out), .busy(busy), .mem_wr(mem_wr),
        .mem_done(mem_done), .return_control(return_control), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    fts_mem_model mem_u (.clk(clk), .reset(reset), .mem_wr(mem_wr), .mem_done(mem_done),
        .delay(dly), .last_data(last_data));
    // {overflow, integer}: truncation, alignment, complement and saturation
    function automatic logic [16:0] fts_expect(fts_pkg::fts_acc_t a);
        logic [47:0] s;
        logic [7:0]  t;
        if (!a.exp[7]) return 17'h0_0000;
        t = a.exp - 8'h80;
        s = a.frac >> (8'd15 - t);
        if (t <= 8'd15) return {1'b0, a.sign ? 16'h0000 - s[47:32] : s[47:32]};
        if (!a.sign) return 17'h1_7FFF;
        s = (a.frac << 1) + 48'h8000_0000_0000;
        return {(t != 8'd16) || (s[47:32] != 16'h0000), 16'h8000};
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one avalon access; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        avs_address   <= adr;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // second idle edge lets irq follow a status or mask write
        repeat (2) @(posedge clk);
    endtask
    task automatic conv(input fts_pkg::fts_acc_t a);
        logic [16:0] e;
        e = fts_expect(a);
        acc_in     <= a;
        store_addr <= 16'($random(seed));
        dly        <= 4'($random(seed));
        start      <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do @(negedge clk); while (busy !== 1'b0);
        @(posedge clk);
        `CHK(last_data, e[15:0])
        `CHK(acc_out, a)
        `CHK(mem_wr.addr, store_addr)
        bus(1'b0, 4'h0, 32'h0);
        `CHK(r[0], e[16])
        `CHK(irq, e[16] & mask_on[0])
        if (mask_on) bus(1'b1, 4'h0, 32'h3);
    endtask
    initial begin
        seed = 62544;
        mask_on = 1;
        {reset, start, avs_read, avs_write} = 4'h8;
        {acc_in, store_addr, avs_address, avs_writedata, dly} = '0;
        avs_byteenable = 4'hF;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(r, 32'h0000_0000)
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        `CHK(r, 32'h0000_0000)
        foreach (corner[i]) conv(corner[i]);
        repeat (30) conv({1'($random(seed)), 8'h7C + 8'({$random(seed)} % 23),
            2'b01, 46'({$random(seed), $random(seed)})});
        // a masked overflow stays quiet, yet shows once unmasked
        mask_on = 0;
        bus(1'b1, 4'h4, 32'h0);
        conv(corner[6]);
        bus(1'b1, 4'h4, 32'h1);
        `CHK(irq, 1'b1)
        bus(1'b1, 4'h0, 32'h1);
        `CHK(irq, 1'b0)
        end_of_test();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end
endmodule

// *** verif/fts_fix_store_properties.sv ***
// port assertions for the float-to-integer store sequencer
// assumes: bound to fts_fix_store, one clock domain, reset synchronous
`timescale 1ns/1ps
module fts_fix_store_properties (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // datapath and processor side
    input wire logic                 start,
    input wire fts_pkg::fts_acc_t    acc_in,
    input wire fts_pkg::fts_acc_t    acc_out,
    input wire logic                 busy,
    input wire fts_pkg::fts_mem_wr_t mem_wr,
    input wire logic                 mem_done,
    input wire logic                 return_control,
    input wire logic                 irq,
    // register bus
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic                 avs_waitrequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    fts_pkg::fts_acc_t acc_q;
    // keeps the accepted operand so restore and store can be compared to it
    always_ff @(posedge clk) begin
        if (start && !busy) acc_q <= acc_in;
    end
    sequence s_taken; start && !busy; endsequence
    sequence s_done; mem_wr.req && mem_done ##1 (!mem_wr.req && return_control); endsequence
    a_req_hold: assert property (mem_wr.req && !mem_done |=> mem_wr.req && $stable(mem_wr))
        else $error("store request changed before completion");
    a_ret_after: assert property (mem_wr.req && mem_done |-> s_done)
        else $error("control not returned after store completion");
    a_ret_pulse: assert property (return_control |=> !return_control)
        else $error("return pulse longer than one cycle");
    a_busy_start: assert property (s_taken |=> busy)
        else $error("busy missing after start");
    a_zero_store: assert property (s_taken ##0 !acc_in.exp[7] |-> ##4 (mem_wr.req && mem_wr.data == 16'h0000))
        else $error("negative exponent did not store zero");
    a_exact_fifteen: assert property (s_taken ##0 (acc_in.exp == 8'h8F && !acc_in.sign)
        |-> ##6 (mem_wr.req && mem_wr.data == acc_q.frac[47:32]))
        else $error("exponent fifteen not stored unshifted");
    a_restore_acc: assert property ($fell(busy) |-> acc_out == acc_q)
        else $error("accumulator not restored");
    a_irq_sticky: assert property (irq && !avs_write && !$past(avs_write) |=> irq)
        else $error("interrupt dropped without a clear");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("register access not one wait cycle");
endmodule
bind fts_fix_store fts_fix_store_properties chk_u (.clk(clk), .reset(reset), .start(start),
    .acc_in(acc_in), .acc_out(acc_out), .busy(busy), .mem_wr(mem_wr), .mem_done(mem_done),
    .return_control(return_control), .irq(irq), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest));

// *** verif/fts_mem_model.sv ***
// memory write partner: acknowledges each store word after a chosen delay
// assumes: same clock as the sequencer, delay steady during a store
`timescale 1ns/1ps
module fts_mem_model (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // memory bus
    input  wire fts_pkg::fts_mem_wr_t mem_wr,
    output logic                      mem_done,
    // control and observation
    input  wire logic [3:0]           delay,
    output logic [15:0]               last_data
);
    logic [3:0] wait_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_done <= 1'b0;
            wait_q   <= 4'h0;
        end else if (mem_wr.req && !mem_done) begin
            if (wait_q == delay) begin
                mem_done  <= 1'b1;
                last_data <= mem_wr.data;
                wait_q    <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            mem_done <= 1'b0;
        end
    end
endmodule
